// ===== flr_consts.svh
`ifndef FLR_CONSTS_SVH
`define FLR_CONSTS_SVH
// Register offsets
`define FLR_ADDR_CTRL 4'h0
`define FLR_ADDR_STATUS 4'h1
`define FLR_ADDR_RATIO 4'h2
`define FLR_ADDR_JTAGDIV 4'h3
// Recovery data register
`define FLR_DIV_W 7
`define FLR_PRESCALE_BIT 6
`define FLR_RATIO_MSB 5
// Control fields and ratio reset value
`define FLR_CTRL_KEYPERMIT 0
`define FLR_CTRL_KEYOPEN 1
`define FLR_RATIO_RESET 7'h00
// JTAG instructions
`define FLR_IR_W 4
`define FLR_IR_IDCODE 4'h2
`define FLR_IR_RECOVERY 4'h8
`define FLR_IR_BYPASS 4'hf
// Erase length in timed-clock ticks
`define FLR_ERASE_TICKS 16'h0100
// Identity value is arbitrary
`define FLR_IDCODE 32'h0a5a5001
`endif

// ===== flr_jtag_host.sv
`timescale 1ns/1ps
module flr_jtag_host (
  input wire logic clk_sys,
  input wire logic tdo_r,
  input wire logic tdoOe_r,
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trstN
);
  logic tdoLast;
  logic tdoSeen;
  // Released line shows inverse, never a stale bit
  always_ff @(posedge clk_sys) if (!tdoOe_r) tdoLast <= tdo_r;
  assign tdoSeen = tdoOe_r ? ~tdoLast : tdo_r;
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trstN = 1'b0;
  end
  // Six clocks high and twelve low per period, sync needs four
  task automatic step(input logic m, input logic d, output logic q);
    repeat (6) @(posedge clk_sys);
    q = tdoSeen;
    tms <= m;
    tdi <= d;
    repeat (6) @(posedge clk_sys);
    tck <= 1'b1;
    repeat (6) @(posedge clk_sys);
    tck <= 1'b0;
  endtask
  task automatic shift(input logic ir, input int n, input logic [31:0] v, output logic [31:0] r);
    logic q;
    r = 32'h0;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, v[i], q);
      r[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
  task automatic tapReset();
    logic q;
    trstN <= 1'b0;
    repeat (8) @(posedge clk_sys);
    trstN <= 1'b1;
    step(1'b0, 1'b0, q);
  endtask
endmodule

// ===== flr_lockout_recovery.sv
`timescale 1ns/1ps
`include "flr_consts.svh"
module flr_lockout_recovery (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trstN,
  output logic tdo_r,
  output logic tdoOe_r,
  input wire logic secureBytes,
  input wire logic dbgReq,
  output logic dbgGrant_r,
  output logic readDisable_r,
  output logic eraseAll_r,
  output logic prescale_r,
  output logic [5:0] ratio_r,
  output logic timedTick_r,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata_r
);
  logic [2:0] tckS_r, tmsS_r, tdiS_r, trstS_r;
  logic tckQ_r, trstQ_r;
  logic strapDone_r, secure_r, recovering_r, permit_r, keyOpen_r, divLoaded_r;
  logic [6:0] ratioReg_r, divReg_r, divShift_r;
  logic [3:0] ir_r, irShift_r;
  logic [31:0] idShift_r;
  logic bypass_r;
  logic [9:0] divCnt_r;
  logic [15:0] eraseCnt_r;
  flr_pkg::flr_tap_t tap_r, tapNxt;
  flr_pkg::flr_rec_t rec_r;
  logic tckRise, tckFall, tapRst;
  // Only agreed tck and trst samples count; first stage feeds nothing else
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      tckS_r <= 3'h0; tmsS_r <= 3'h7; tdiS_r <= 3'h0; trstS_r <= 3'h0;
      tckQ_r <= 1'b0; trstQ_r <= 1'b0;
    end
    else if (clkEn)
    begin
      tckS_r <= {tckS_r[1:0], tck}; tmsS_r <= {tmsS_r[1:0], tms};
      tdiS_r <= {tdiS_r[1:0], tdi}; trstS_r <= {trstS_r[1:0], trstN};
      if (tckS_r[1] == tckS_r[2]) tckQ_r <= tckS_r[2];
      if (trstS_r[1] == trstS_r[2]) trstQ_r <= trstS_r[2];
    end
  assign tckRise = clkEn && (tckS_r[1] == tckS_r[2]) && tckS_r[2] && !tckQ_r;
  assign tckFall = clkEn && (tckS_r[1] == tckS_r[2]) && !tckS_r[2] && tckQ_r;
  assign tapRst = !trstQ_r;
  always_comb
  begin
    tapNxt = tap_r;
    case (tap_r)
      flr_pkg::TapReset: tapNxt = tmsS_r[2] ? flr_pkg::TapReset : flr_pkg::TapIdle;
      flr_pkg::TapIdle: tapNxt = tmsS_r[2] ? flr_pkg::TapSelDr : flr_pkg::TapIdle;
      flr_pkg::TapSelDr: tapNxt = tmsS_r[2] ? flr_pkg::TapSelIr : flr_pkg::TapCapDr;
      flr_pkg::TapCapDr: tapNxt = tmsS_r[2] ? flr_pkg::TapEx1Dr : flr_pkg::TapShDr;
      flr_pkg::TapShDr: tapNxt = tmsS_r[2] ? flr_pkg::TapEx1Dr : flr_pkg::TapShDr;
      flr_pkg::TapEx1Dr: tapNxt = tmsS_r[2] ? flr_pkg::TapUpdDr : flr_pkg::TapPauseDr;
      flr_pkg::TapPauseDr: tapNxt = tmsS_r[2] ? flr_pkg::TapEx2Dr : flr_pkg::TapPauseDr;
      flr_pkg::TapEx2Dr: tapNxt = tmsS_r[2] ? flr_pkg::TapUpdDr : flr_pkg::TapShDr;
      flr_pkg::TapUpdDr: tapNxt = tmsS_r[2] ? flr_pkg::TapSelDr : flr_pkg::TapIdle;
      flr_pkg::TapSelIr: tapNxt = tmsS_r[2] ? flr_pkg::TapReset : flr_pkg::TapCapIr;
      flr_pkg::TapCapIr: tapNxt = tmsS_r[2] ? flr_pkg::TapEx1Ir : flr_pkg::TapShIr;
      flr_pkg::TapShIr: tapNxt = tmsS_r[2] ? flr_pkg::TapEx1Ir : flr_pkg::TapShIr;
      flr_pkg::TapEx1Ir: tapNxt = tmsS_r[2] ? flr_pkg::TapUpdIr : flr_pkg::TapPauseIr;
      flr_pkg::TapPauseIr: tapNxt = tmsS_r[2] ? flr_pkg::TapEx2Ir : flr_pkg::TapPauseIr;
      flr_pkg::TapEx2Ir: tapNxt = tmsS_r[2] ? flr_pkg::TapUpdIr : flr_pkg::TapShIr;
      flr_pkg::TapUpdIr: tapNxt = tmsS_r[2] ? flr_pkg::TapSelDr : flr_pkg::TapIdle;
      default: tapNxt = flr_pkg::TapReset;
    endcase
  end
  // TAP live from boot
  // tap and ID
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      tap_r <= flr_pkg::TapReset;
      ir_r <= `FLR_IR_IDCODE;
      irShift_r <= 4'h0; idShift_r <= 32'h0; bypass_r <= 1'b0; divShift_r <= 7'h0;
      divReg_r <= 7'h0; divLoaded_r <= 1'b0;
    end
    else if (clkEn)
    begin
      if (tapRst)
      begin
        tap_r <= flr_pkg::TapReset;
        ir_r <= `FLR_IR_IDCODE;
        divLoaded_r <= 1'b0;
      end
      else if (tckRise)
      begin
        tap_r <= tapNxt;
        if (tapNxt == flr_pkg::TapReset) ir_r <= `FLR_IR_IDCODE;
        case (tap_r)
          flr_pkg::TapCapIr: irShift_r <= 4'h1;
          flr_pkg::TapShIr: irShift_r <= {tdiS_r[2], irShift_r[3:1]};
          flr_pkg::TapUpdIr: ir_r <= irShift_r;
          flr_pkg::TapCapDr:
          begin
            idShift_r <= `FLR_IDCODE; bypass_r <= 1'b0; divShift_r <= divReg_r;
          end
          flr_pkg::TapShDr:
          begin
            idShift_r <= {tdiS_r[2], idShift_r[31:1]};
            bypass_r <= tdiS_r[2];
            divShift_r <= {tdiS_r[2], divShift_r[6:1]};
          end
          flr_pkg::TapUpdDr:
            if (ir_r == `FLR_IR_RECOVERY)
            begin
              divReg_r <= divShift_r;
              divLoaded_r <= 1'b1;
            end
          default: ;
        endcase
      end
    end
  // Output shifted on falling test clock
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      tdo_r <= 1'b0; tdoOe_r <= 1'b1;
    end
    else if (clkEn && tckFall)
    begin
      tdoOe_r <= !(tap_r == flr_pkg::TapShDr || tap_r == flr_pkg::TapShIr);
      if (tap_r == flr_pkg::TapShIr) tdo_r <= irShift_r[0];
      else if (ir_r == `FLR_IR_IDCODE) tdo_r <= idShift_r[0];
      else if (ir_r == `FLR_IR_RECOVERY) tdo_r <= divShift_r[0];
      else tdo_r <= bypass_r;
    end
  // Strap caught on first clock after release, then frozen
  // security from bytes
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      strapDone_r <= 1'b0; secure_r <= 1'b1; readDisable_r <= 1'b1;
    end
    else if (clkEn && !strapDone_r)
    begin
      strapDone_r <= 1'b1; secure_r <= secureBytes; readDisable_r <= secureBytes;
    end
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      dbgGrant_r <= 1'b0;
    else if (clkEn)
      dbgGrant_r <= dbgReq && strapDone_r && (!secure_r || (permit_r && keyOpen_r)) && !recovering_r;
  // Recovery sequencer; erase starts on the same Update-DR edge that loads the divider
  // start on idle entry
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      rec_r <= flr_pkg::RecIdle; eraseAll_r <= 1'b0; eraseCnt_r <= 16'h0; recovering_r <= 1'b0;
    end
    else if (clkEn)
      case (rec_r)
        flr_pkg::RecIdle:
          if (!tapRst && tckRise && tap_r == flr_pkg::TapUpdDr && tapNxt == flr_pkg::TapIdle &&
              ir_r == `FLR_IR_RECOVERY)
          begin
            rec_r <= flr_pkg::RecErase; eraseAll_r <= 1'b1; recovering_r <= 1'b1; eraseCnt_r <= 16'h0;
          end
        flr_pkg::RecErase:
          // Leaving idle early aborts; flash state is then undefined
          if (tap_r != flr_pkg::TapIdle)
          begin
            rec_r <= flr_pkg::RecIdle; eraseAll_r <= 1'b0; recovering_r <= 1'b0;
          end
          else if (timedTick_r)
          begin
            if (eraseCnt_r == `FLR_ERASE_TICKS - 16'h1)
            begin
              rec_r <= flr_pkg::RecDone; eraseAll_r <= 1'b0; recovering_r <= 1'b0;
            end
            eraseCnt_r <= eraseCnt_r + 16'h1;
          end
        flr_pkg::RecDone: ;
        default: rec_r <= flr_pkg::RecIdle;
      endcase
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      prescale_r <= 1'b0; ratio_r <= 6'h0;
    end
    else if (clkEn)
    begin
      prescale_r <= recovering_r ? divReg_r[`FLR_PRESCALE_BIT] : ratioReg_r[`FLR_PRESCALE_BIT];
      ratio_r <= recovering_r ? divReg_r[`FLR_RATIO_MSB:0] : ratioReg_r[`FLR_RATIO_MSB:0];
    end
  // Flash timing divider counts every system clock while clkEn is set
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      divCnt_r <= 10'h0; timedTick_r <= 1'b0;
    end
    else if (clkEn)
    begin
      timedTick_r <= 1'b0;
      // Period is 2*(ratio+1), times 8 with prescale; both terms fit 10 bits
      if (divCnt_r >= (prescale_r ? {ratio_r, 4'hf} : {3'h0, ratio_r, 1'b1}))
      begin
        divCnt_r <= 10'h0; timedTick_r <= 1'b1;
      end
      else
        divCnt_r <= divCnt_r + 10'h1;
    end
  // Software registers
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      ratioReg_r <= `FLR_RATIO_RESET; permit_r <= 1'b0; keyOpen_r <= 1'b0; rdata_r <= 8'h0;
    end
    else if (clkEn)
    begin
      if (wr && addr == `FLR_ADDR_CTRL)
      begin
        permit_r <= wdata[`FLR_CTRL_KEYPERMIT]; keyOpen_r <= wdata[`FLR_CTRL_KEYOPEN];
      end
      if (wr && addr == `FLR_ADDR_RATIO) ratioReg_r <= wdata[6:0];
      rdata_r <= 8'h0;
      if (rd)
        case (addr)
          `FLR_ADDR_CTRL: rdata_r <= {6'h0, keyOpen_r, permit_r};
          `FLR_ADDR_STATUS: rdata_r <= {3'h0, divLoaded_r, rec_r == flr_pkg::RecDone, recovering_r,
                                        dbgGrant_r, secure_r};
          `FLR_ADDR_RATIO: rdata_r <= {1'b0, ratioReg_r};
          `FLR_ADDR_JTAGDIV: rdata_r <= {1'b0, divReg_r};
          default: rdata_r <= 8'h0;
        endcase
    end
  property p_noDbgSecure;
    @(posedge clk_sys) disable iff (rst) (secure_r && !(permit_r && keyOpen_r)) |=> !dbgGrant_r;
  endproperty
  a_noDbgSecure: assert property (p_noDbgSecure) else $error("debug granted while secure");
  property p_holdSec;
    @(posedge clk_sys) disable iff (rst) strapDone_r |=> $stable(readDisable_r);
  endproperty
  a_holdSec: assert property (p_holdSec) else $error("read disable changed");
  property p_override;
    @(posedge clk_sys) disable iff (rst) (clkEn && recovering_r) |=> prescale_r == divReg_r[6];
  endproperty
  a_override: assert property (p_override) else $error("prescale not from JTAG");
  property p_ratioOverride;
    @(posedge clk_sys) disable iff (rst) (clkEn && recovering_r) |=> ratio_r == divReg_r[`FLR_RATIO_MSB:0];
  endproperty
  a_ratioOverride: assert property (p_ratioOverride) else $error("ratio not from JTAG");
  property p_strapSec;
    @(posedge clk_sys) disable iff (rst) $rose(strapDone_r) |-> readDisable_r == $past(secureBytes);
  endproperty
  a_strapSec: assert property (p_strapSec) else $error("read disable not from security bytes");
  sequence s_start;
    rec_r == flr_pkg::RecIdle ##1 rec_r == flr_pkg::RecErase;
  endsequence
  property p_start;
    @(posedge clk_sys) disable iff (rst) s_start |-> eraseAll_r && $past(ir_r) == `FLR_IR_RECOVERY;
  endproperty
  a_start: assert property (p_start) else $error("erase started wrongly");
endmodule

// ===== flr_pkg.sv
package flr_pkg;
  typedef enum logic [3:0] {
    TapReset, TapIdle, TapSelDr, TapCapDr, TapShDr, TapEx1Dr, TapPauseDr, TapEx2Dr, TapUpdDr,
    TapSelIr, TapCapIr, TapShIr, TapEx1Ir, TapPauseIr, TapEx2Ir, TapUpdIr
  } flr_tap_t;
  typedef enum logic [1:0] {
    RecIdle, RecErase, RecDone
  } flr_rec_t;
endpackage

// ===== tb_top.sv
`timescale 1ns/1ps
`include "flr_consts.svh"
module tb_top;
  logic clk_sys, rst, tck, tms, tdi, trstN, tdo_r, tdoOe_r, secureBytes, dbgReq, dbgGrant_r, readDisable_r;
  logic eraseAll_r, prescale_r, timedTick_r, wr, rd, clkEn;
  logic [5:0] ratio_r;
  logic [3:0] addr;
  logic [7:0] wdata, rdata_r, rv;
  logic [31:0] jr;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  flr_lockout_recovery uut (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .tck(tck), .tms(tms), .tdi(tdi),
    .trstN(trstN), .tdo_r(tdo_r), .tdoOe_r(tdoOe_r), .secureBytes(secureBytes), .dbgReq(dbgReq),
    .dbgGrant_r(dbgGrant_r), .readDisable_r(readDisable_r), .eraseAll_r(eraseAll_r), .prescale_r(prescale_r),
    .ratio_r(ratio_r), .timedTick_r(timedTick_r), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r));
  flr_jtag_host host (.clk_sys(clk_sys), .tdo_r(tdo_r), .tdoOe_r(tdoOe_r), .tck(tck), .tms(tms), .tdi(tdi),
    .trstN(trstN));
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Ceiling well above the 27k-clock erase
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      err_total = err_total + 1;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrReg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rdReg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata_r;
  endtask
  task automatic doReset(input logic s);
    secureBytes <= s;
    rst <= 1'b1;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic t_boot();
    chk("readDisable", 1, readDisable_r);
    chk("dbgGrant", 0, dbgGrant_r);
    host.shift(1'b0, 32, 32'h0, jr);
    chk("idcode", `FLR_IDCODE, jr);
    chk("tdoRelease", 1, tdoOe_r);
    host.shift(1'b1, `FLR_IR_W, `FLR_IR_BYPASS, jr);
    host.shift(1'b0, 2, 32'h1, jr);
    chk("bypass", 32'h2, jr);
  endtask
  task automatic t_key();
    wrReg(`FLR_ADDR_CTRL, 8'h02);
    repeat (3) @(posedge clk_sys);
    chk("grantNoPermit", 0, dbgGrant_r);
    wrReg(`FLR_ADDR_CTRL, 8'h03);
    repeat (3) @(posedge clk_sys);
    chk("grantPermit", 1, dbgGrant_r);
    // Frozen block must ignore the write
    clkEn <= 1'b0;
    wrReg(`FLR_ADDR_CTRL, 8'h00);
    clkEn <= 1'b1;
    rdReg(`FLR_ADDR_CTRL, rv);
    chk("freezeCtrl", 8'h03, rv);
    wrReg(`FLR_ADDR_CTRL, 8'h00);
    rdReg(4'hf, rv);
    chk("unmapped", 0, rv);
  endtask
  task automatic t_recovery();
    int n;
    wrReg(`FLR_ADDR_RATIO, 8'h45);
    repeat (3) @(posedge clk_sys);
    chk("prescaleOwn", 1, prescale_r);
    chk("ratioOwn", 5, ratio_r);
    host.shift(1'b1, `FLR_IR_W, `FLR_IR_RECOVERY, jr);
    // prescale clear below 12.8 MHz, ratio 52 gives 189 kHz
    host.shift(1'b0, `FLR_DIV_W, 32'h34, jr);
    repeat (8) @(posedge clk_sys);
    chk("eraseAll", 1, eraseAll_r);
    chk("prescale", 0, prescale_r);
    chk("ratio", 52, ratio_r);
    @(posedge timedTick_r);
    n = 0;
    // Sampled after the edge so the pulse just seen is not counted again
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (timedTick_r !== 1'b1 && n < 200);
    chk("tickPeriod", 106, n);
    n = 0;
    while (eraseAll_r === 1'b1 && n < 30000)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk("eraseEnd", 0, eraseAll_r);
    chk("eraseLen", 1, n > 256 * 106 - 400);
    chk("holdDisable", 1, readDisable_r);
    rdReg(`FLR_ADDR_STATUS, rv);
    chk("statusDone", 2'b11, rv[4:3]);
    rdReg(`FLR_ADDR_JTAGDIV, rv);
    chk("jtagDiv", 8'h34, rv);
    host.tapReset();
    doReset(1'b0);
    chk("unsecDisable", 0, readDisable_r);
    chk("unsecGrant", 1, dbgGrant_r);
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    rst = 1'b1;
    secureBytes = 1'b1;
    dbgReq = 1'b1;
    clkEn = 1'b1;
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    doReset(1'b1);
    host.tapReset();
    t_boot();
    t_key();
    t_recovery();
    finish_test();
  end
endmodule
